/* design/compressor_rates_and_tone_control.sv */
// Compressor rate registers and tone generator control
// Notes on behaviour
// RULE1: Attack code 0 means 4 dB per word clock, each code halves it.
// RULE2: Decay step is 0.015625 dB divided by two to the decay code.
// RULE3: Tone enable starts the tone, self-clears at end, zero keeps it off.
// RULE4: Tone sounds only in the tone-capable processing mode.
// RULE5: Left tone volume is +2 dB at code 0, minus 1 dB per code.
// RULE6: Right tone volume decodes the same, down to -61 dB.
// RULE7: Link field 01 copies right to left, 10 left to right, else own.
// RULE8: Length high byte register supplies the top eight of 24 length bits.
// RULE9: Host writes the reserved left-control bit only with its reset value.
// RULE10: Middle and low length bytes complete the count; low resets to 0xEE.
// RULE11: Tone comes from 16-bit sine and cosine coefficients, split in bytes.
// RULE12: Count one per sample while playing, stop at length, clear enable.
`timescale 1ns/10ps
`default_nettype none
module compressor_rates_and_tone_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Processing mode from the DAC path
  input wire logic toneCapableMode,
  // Compressor rates, 24 fractional bits
  output logic [tone_ctrl_pkg::STEP_W-1:0] attackStep,
  output logic [tone_ctrl_pkg::STEP_W-1:0] decayStep,
  // Tone output
  output logic toneActive,
  output logic toneDone,
  output logic sampleTick,
  output logic signed [15:0] toneSample,
  output logic signed [6:0] leftGainDb,
  output logic signed [6:0] rightGainDb
);
  import tone_ctrl_pkg::*;

  typedef enum logic [1:0] {TONE_IDLE, TONE_START, TONE_RUN} tone_state_t;

  // Registers
  logic [7:0] rateCtrl;
  logic toneEnable;
  logic leftReserved;
  logic [5:0] leftVolume;
  logic [1:0] volumeLink;
  logic [5:0] rightVolume;
  logic [7:0] lengthHigh;
  logic [7:0] lengthMid;
  logic [7:0] lengthLow;
  logic [7:0] sinHigh;
  logic [7:0] sinLow;
  logic [7:0] cosHigh;
  logic [7:0] cosLow;

  // Tone sequencing
  tone_state_t toneState;
  tone_state_t next_toneState;
  logic [DIV_W-1:0] divCount;
  logic [LEN_W-1:0] sampleCount;
  logic [LEN_W-1:0] toneLength;
  logic lastSample;
  logic finish;
  logic oscLoad;
  logic oscStep;
  logic signed [15:0] oscSample;
  logic [5:0] leftSource;
  logic [5:0] rightSource;
  logic wrRate;
  logic wrLeft;
  logic wrRight;
  logic enableWrite;

  assign wrRate = regWrEn && (regAddr == ADDR_RATE);
  assign wrLeft = regWrEn && (regAddr == ADDR_LEFT);
  assign wrRight = regWrEn && (regAddr == ADDR_RIGHT);
  assign enableWrite = wrLeft && regWrData[TONE_EN_BIT];

  // Compressor rate register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rateCtrl <= RST_RATE;
    end else if (wrRate) begin
      rateCtrl <= regWrData;
    end
  end

  rate_step_decoder rateDecoder (
    .attackCode(rateCtrl[ATTACK_MSB:ATTACK_LSB]),
    .decayCode(rateCtrl[DECAY_MSB:0]),
    .attackStep(attackStep),
    .decayStep(decayStep)
  );

  // Left control fields; the reserved bit is stored as written
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      leftReserved <= RST_LEFT[RESERVED_BIT];
      leftVolume <= RST_LEFT[VOL_MSB:0];
    end else if (wrLeft) begin
      leftReserved <= regWrData[RESERVED_BIT];
      leftVolume <= regWrData[VOL_MSB:0];
    end
  end

  // Tone enable: a host write of one wins over the self-clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      toneEnable <= RST_LEFT[TONE_EN_BIT];
    end else if (wrLeft) begin
      toneEnable <= regWrData[TONE_EN_BIT]; // RULE3
    end else if (finish) begin
      toneEnable <= 1'b0; // RULE3 RULE12
    end
  end

  // Right control and link fields
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      volumeLink <= RST_RIGHT[LINK_MSB:LINK_LSB];
      rightVolume <= RST_RIGHT[VOL_MSB:0];
    end else if (wrRight) begin
      volumeLink <= regWrData[LINK_MSB:LINK_LSB];
      rightVolume <= regWrData[VOL_MSB:0];
    end
  end

  // Length and coefficient bytes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lengthHigh <= RST_LEN_HI;
      lengthMid <= RST_LEN_MID;
      lengthLow <= RST_LEN_LO; // RULE10
      sinHigh <= RST_SIN_HI;
      sinLow <= RST_SIN_LO;
      cosHigh <= RST_COS_HI;
      cosLow <= RST_COS_LO;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_LEN_HI: lengthHigh <= regWrData; // RULE8
        ADDR_LEN_MID: lengthMid <= regWrData; // RULE10
        ADDR_LEN_LO: lengthLow <= regWrData; // RULE10
        ADDR_SIN_HI: sinHigh <= regWrData; // RULE11
        ADDR_SIN_LO: sinLow <= regWrData; // RULE11
        ADDR_COS_HI: cosHigh <= regWrData; // RULE11
        ADDR_COS_LO: cosLow <= regWrData; // RULE11
        default: ;
      endcase
    end
  end

  assign toneLength = {lengthHigh, lengthMid, lengthLow}; // RULE8 RULE10

  // Read-back; the enable bit shows the live, self-cleared state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= UNMAPPED_DATA;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_RATE: regRdData <= rateCtrl;
        ADDR_LEFT: regRdData <= {toneEnable, leftReserved, leftVolume};
        ADDR_RIGHT: regRdData <= {volumeLink, rightVolume};
        ADDR_LEN_HI: regRdData <= lengthHigh;
        ADDR_LEN_MID: regRdData <= lengthMid;
        ADDR_LEN_LO: regRdData <= lengthLow;
        ADDR_SIN_HI: regRdData <= sinHigh;
        ADDR_SIN_LO: regRdData <= sinLow;
        ADDR_COS_HI: regRdData <= cosHigh;
        ADDR_COS_LO: regRdData <= cosLow;
        default: regRdData <= UNMAPPED_DATA;
      endcase
    end
  end

  // Word clock enable from the master clock divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= '0;
      sampleTick <= 1'b0;
    end else if (divCount == DIV_LAST) begin
      divCount <= '0;
      sampleTick <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      sampleTick <= 1'b0;
    end
  end

  // Counting pauses outside the tone mode, so a mode change cannot
  // cut a tone short; the tone resumes when the mode returns
  assign lastSample = (sampleCount + 1'b1) >= toneLength;
  assign oscStep = (toneState == TONE_RUN) && sampleTick && toneCapableMode;
  assign oscLoad = toneState == TONE_START;

  always_comb begin
    next_toneState = toneState;
    finish = 1'b0;
    case (toneState)
      TONE_IDLE: begin
        if (toneEnable) begin
          next_toneState = TONE_START; // RULE3
        end
      end
      TONE_START: begin
        if (!toneEnable) begin
          next_toneState = TONE_IDLE;
        end else if (toneLength == '0) begin
          finish = 1'b1; // RULE12
          next_toneState = TONE_IDLE;
        end else begin
          next_toneState = TONE_RUN;
        end
      end
      TONE_RUN: begin
        if (!toneEnable) begin
          next_toneState = TONE_IDLE; // RULE3
        end else if (oscStep && lastSample) begin
          finish = 1'b1; // RULE12
          next_toneState = TONE_IDLE;
        end
      end
      default: next_toneState = TONE_IDLE;
    endcase
    // A fresh enable written during the last sample restarts the tone
    if (enableWrite) begin
      next_toneState = TONE_START;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      toneState <= TONE_IDLE;
    end else begin
      toneState <= next_toneState;
    end
  end

  // Sample counter for the tone length
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sampleCount <= '0;
    end else if (toneState != TONE_RUN) begin
      sampleCount <= '0;
    end else if (oscStep) begin
      sampleCount <= sampleCount + 1'b1; // RULE12
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      toneDone <= 1'b0;
    end else begin
      toneDone <= finish;
    end
  end

  sine_oscillator oscillator (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(oscLoad),
    .step(oscStep),
    .sinCoef({sinHigh, sinLow}),
    .cosCoef({cosHigh, cosLow}),
    .sample(oscSample)
  );

  // Output muted unless playing in the tone-capable mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      toneActive <= 1'b0;
      toneSample <= 16'h0000;
    end else if ((toneState == TONE_RUN) && toneCapableMode) begin
      toneActive <= 1'b1; // RULE4
      toneSample <= oscSample; // RULE4
    end else begin
      toneActive <= 1'b0;
      toneSample <= 16'h0000; // RULE4
    end
  end

  // Volume sources chosen by the link field
  always_comb begin
    leftSource = leftVolume;
    rightSource = rightVolume;
    case (volumeLink)
      LINK_LEFT_FROM_RIGHT: leftSource = rightVolume; // RULE7
      LINK_RIGHT_FROM_LEFT: rightSource = leftVolume; // RULE7
      default: ; // RULE7
    endcase
  end

  // Gain in dB is the top gain minus the code
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      leftGainDb <= GAIN_TOP_DB;
      rightGainDb <= GAIN_TOP_DB;
    end else begin
      leftGainDb <= GAIN_TOP_DB - $signed({1'b0, leftSource}); // RULE5
      rightGainDb <= GAIN_TOP_DB - $signed({1'b0, rightSource}); // RULE6
    end
  end
endmodule : compressor_rates_and_tone_control
`default_nettype wire

/* design/tone_ctrl_pkg.sv */
// Shared constants for the compressor rate and tone control block
package tone_ctrl_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RATE = 8'h46;
  localparam logic [7:0] ADDR_LEFT = 8'h47;
  localparam logic [7:0] ADDR_RIGHT = 8'h48;
  localparam logic [7:0] ADDR_LEN_HI = 8'h49;
  localparam logic [7:0] ADDR_LEN_MID = 8'h4A;
  localparam logic [7:0] ADDR_LEN_LO = 8'h4B;
  localparam logic [7:0] ADDR_SIN_HI = 8'h4C;
  localparam logic [7:0] ADDR_SIN_LO = 8'h4D;
  localparam logic [7:0] ADDR_COS_HI = 8'h4E;
  localparam logic [7:0] ADDR_COS_LO = 8'h4F;
  // Reset values
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_LEFT = 8'h00;
  localparam logic [7:0] RST_RIGHT = 8'h00;
  localparam logic [7:0] RST_LEN_HI = 8'h00;
  localparam logic [7:0] RST_LEN_MID = 8'h00;
  localparam logic [7:0] RST_LEN_LO = 8'hEE;
  localparam logic [7:0] RST_SIN_HI = 8'h10;
  localparam logic [7:0] RST_SIN_LO = 8'hD8;
  localparam logic [7:0] RST_COS_HI = 8'h7E;
  localparam logic [7:0] RST_COS_LO = 8'hE3;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // Field positions
  localparam int TONE_EN_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int VOL_MSB = 5;
  localparam int LINK_MSB = 7;
  localparam int LINK_LSB = 6;
  localparam int ATTACK_MSB = 7;
  localparam int ATTACK_LSB = 4;
  localparam int DECAY_MSB = 3;
  // Volume link modes
  localparam logic [1:0] LINK_INDEPENDENT = 2'h0;
  localparam logic [1:0] LINK_LEFT_FROM_RIGHT = 2'h1;
  localparam logic [1:0] LINK_RIGHT_FROM_LEFT = 2'h2;
  // Rate steps: dB per word clock, unsigned, 24 fractional bits
  localparam int STEP_W = 27;
  localparam int STEP_FRAC = 24;
  localparam logic [26:0] ATTACK_BASE = 27'h400_0000;
  localparam logic [26:0] BASE_DECAY_STEP = 27'h004_0000;
  // Tone gain in dB: top gain minus the code
  localparam logic signed [6:0] GAIN_TOP_DB = 7'h02;
  // Oscillator coefficients are Q1.15, doubled by shifting one less
  localparam int OSC_SHIFT = 14;
  localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SAMPLE_MIN = -16'sh7FFF;
  // Sample rate enable
  localparam int MCLK_HZ = 40_000_000;
  localparam int SAMPLE_HZ = 48_000;
  localparam int SAMPLE_DIV = MCLK_HZ / SAMPLE_HZ;
  localparam int DIV_W = 10;
  localparam logic [9:0] DIV_LAST = 10'(SAMPLE_DIV - 1);
  localparam int LEN_W = 24;
endpackage : tone_ctrl_pkg

/* design/rate_step_decoder.sv */
// Decodes compressor attack and decay codes into dB-per-word-clock steps
`timescale 1ns/10ps
`default_nettype none
module rate_step_decoder (
  // Codes
  input wire logic [3:0] attackCode,
  input wire logic [3:0] decayCode,
  // Steps, 24 fractional bits
  output logic [tone_ctrl_pkg::STEP_W-1:0] attackStep,
  output logic [tone_ctrl_pkg::STEP_W-1:0] decayStep
);
  import tone_ctrl_pkg::*;

  // Each code step halves the rate; smallest steps stay exact in 24 bits
  assign attackStep = ATTACK_BASE >> attackCode; // RULE1
  assign decayStep = BASE_DECAY_STEP >> decayCode; // RULE2
endmodule : rate_step_decoder
`default_nettype wire

/* design/sine_oscillator.sv */
// Two-term recursive sine oscillator stepped once per sample
`timescale 1ns/10ps
`default_nettype none
module sine_oscillator (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic step,
  input wire logic signed [15:0] sinCoef,
  input wire logic signed [15:0] cosCoef,
  // Output
  output logic signed [15:0] sample
);
  import tone_ctrl_pkg::*;

  logic signed [15:0] prev;
  logic signed [31:0] product;
  logic signed [33:0] wide;
  logic signed [15:0] next_sample;

  // y[n] = 2 cos(w) y[n-1] - y[n-2], saturated so rounding cannot wrap
  always_comb begin
    product = cosCoef * sample;
    wide = 34'(product >>> OSC_SHIFT) - 34'(prev);
    if (wide > 34'(SAMPLE_MAX)) begin
      next_sample = SAMPLE_MAX;
    end else if (wide < 34'(SAMPLE_MIN)) begin
      next_sample = SAMPLE_MIN;
    end else begin
      next_sample = wide[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample <= 16'h0000;
      prev <= 16'h0000;
    end else if (load) begin
      sample <= sinCoef; // RULE11
      prev <= 16'h0000;
    end else if (step) begin
      sample <= next_sample; // RULE11
      prev <= sample;
    end
  end
endmodule : sine_oscillator
`default_nettype wire

/* sim/compressor_rates_checker.sv */
// Port-level assertions for the compressor rate and tone control block
`timescale 1ns/10ps
`default_nettype none
module compressor_rates_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // Mode and outputs
  input wire logic toneCapableMode,
  input wire logic [tone_ctrl_pkg::STEP_W-1:0] attackStep,
  input wire logic [tone_ctrl_pkg::STEP_W-1:0] decayStep,
  input wire logic toneActive,
  input wire logic toneDone,
  input wire logic sampleTick,
  input wire logic signed [15:0] toneSample,
  input wire logic signed [6:0] leftGainDb,
  input wire logic signed [6:0] rightGainDb
);
  import tone_ctrl_pkg::*;
  logic [9:0] gap;
  logic seen;
  // The first tick after reset has no reference, so it is skipped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 10'h000;
      seen <= 1'b0;
    end else if (sampleTick) begin
      gap <= 10'h000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 10'h001;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence rateWr;
    regWrEn && regAddr == ADDR_RATE;
  endsequence
  sequence hiWrRd;
    regWrEn && regAddr == ADDR_LEN_HI ##1 !regWrEn
      ##1 regRdEn && !regWrEn && regAddr == ADDR_LEN_HI;
  endsequence
  sequence stopWr;
    regWrEn && regAddr == ADDR_LEFT && !regWrData[TONE_EN_BIT] ##1 !regWrEn;
  endsequence
  sequence modeOff;
    !toneCapableMode [*2];
  endsequence
  AST_ATTACK: assert property (
    rateWr |=> attackStep == ATTACK_BASE >> $past(regWrData[7:4]))
    else $error("attack step does not follow its code");
  AST_DECAY: assert property (
    rateWr |=> decayStep == BASE_DECAY_STEP >> $past(regWrData[3:0]))
    else $error("decay step does not follow its code");
  AST_LEN_HI: assert property (
    hiWrRd |=> regRdData == $past(regWrData, 3))
    else $error("length high byte not read back");
  // The state leaves the run one edge after the write, and the registered
  // active flag follows one edge later still
  AST_STOP: assert property (
    stopWr |=> ##1 !toneActive)
    else $error("tone still active after enable cleared");
  AST_MODE: assert property (
    modeOff |-> !toneActive)
    else $error("tone active outside tone mode");
  AST_SILENT: assert property (
    !toneActive && !$past(toneActive) |-> toneSample == 16'sh0000)
    else $error("tone sample not zero while idle");
  // The end pulse and the last active cycle are registered from the same
  // state, so they overlap by one cycle; both must be gone one cycle later
  AST_DONE: assert property (
    toneDone |=> !toneDone && !toneActive)
    else $error("tone end pulse malformed");
  AST_TICK: assert property (
    sampleTick && seen |-> gap == DIV_LAST)
    else $error("sample tick spacing wrong");
endmodule : compressor_rates_checker
bind compressor_rates_and_tone_control compressor_rates_checker
  compressor_rates_checker_inst (.mclk(mclk), .rst_b(rst_b),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData),
  .toneCapableMode(toneCapableMode), .attackStep(attackStep),
  .decayStep(decayStep), .toneActive(toneActive), .toneDone(toneDone),
  .sampleTick(sampleTick), .toneSample(toneSample),
  .leftGainDb(leftGainDb), .rightGainDb(rightGainDb));
`default_nettype wire

/* sim/test_compressor_rates_and_tone_control.sv */
// Self-checking bench for the compressor rate and tone control block
`timescale 1ns/10ps
`default_nettype none
module test_compressor_rates_and_tone_control;
  import tone_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic toneCapableMode = 1'b1;
  logic [7:0] regRdData;
  logic [STEP_W-1:0] attackStep;
  logic [STEP_W-1:0] decayStep;
  logic toneActive, toneDone, sampleTick, loud;
  logic signed [15:0] toneSample;
  logic signed [6:0] leftGainDb, rightGainDb, gl, gr;
  logic [7:0] rd;
  logic [5:0] cl, cr;
  logic [7:0] rstVal [10] = '{RST_RATE, RST_LEFT, RST_RIGHT, RST_LEN_HI,
    RST_LEN_MID, RST_LEN_LO, RST_SIN_HI, RST_SIN_LO, RST_COS_HI, RST_COS_LO};
  int miscompares = 0;
  int n_tests = 0;
  int n;
  compressor_rates_and_tone_control compressor_rates_and_tone_control_inst (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .toneCapableMode(toneCapableMode), .attackStep(attackStep),
    .decayStep(decayStep), .toneActive(toneActive), .toneDone(toneDone),
    .sampleTick(sampleTick), .toneSample(toneSample),
    .leftGainDb(leftGainDb), .rightGainDb(rightGainDb));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rdReg(input logic [7:0] a);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    rd = regRdData;
  endtask : rdReg
  // Aligning to a tick keeps the count of played samples exact
  task automatic waitTick();
    int i;
    for (i = 0; i < 1000; i++) begin
      @(negedge mclk);
      if (sampleTick === 1'b1) break;
    end
    if (i == 1000) begin
      miscompares++;
      complete_run();
    end
  endtask : waitTick
  task automatic play(output int ticks);
    int i;
    ticks = 0;
    loud = 1'b0;
    for (i = 0; i < 5000; i++) begin
      @(negedge mclk);
      if (toneDone === 1'b1) break;
      if (sampleTick === 1'b1) ticks++;
      if (toneActive === 1'b1 && toneSample !== 16'sh0000) loud = 1'b1;
    end
    if (i == 5000) begin
      miscompares++;
      complete_run();
    end
  endtask : play
  initial begin
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    for (int a = 0; a < 10; a++) begin
      rdReg(ADDR_RATE + 8'(a));
      check(rd, rstVal[a]);
    end
    rdReg(8'h50);
    check(rd, UNMAPPED_DATA);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_RATE, {4'(c), 4'(15 - c)});
      check(attackStep, ATTACK_BASE >> c);
      check(decayStep, BASE_DECAY_STEP >> (15 - c));
    end
    wr(ADDR_LEN_HI, 8'hA5);
    rdReg(ADDR_LEN_HI);
    check(rd, 8'hA5);
    wr(ADDR_LEN_HI, 8'h00);
    $display("test rates done");
    for (int k = 0; k < 8; k++) begin
      cl = k[2] ? 6'h00 : 6'h3F;
      cr = k[2] ? 6'h01 : 6'h3E;
      wr(ADDR_LEFT, {2'b00, cl});
      wr(ADDR_RIGHT, {2'(k), cr});
      repeat (3) @(negedge mclk);
      gl = 7'h02 - 7'(2'(k) == LINK_LEFT_FROM_RIGHT ? cr : cl);
      gr = 7'h02 - 7'(2'(k) == LINK_RIGHT_FROM_LEFT ? cl : cr);
      check(leftGainDb, gl);
      check(rightGainDb, gr);
    end
    $display("test gains done");
    wr(ADDR_LEN_LO, 8'h03);
    waitTick();
    wr(ADDR_LEFT, 8'h80);
    play(n);
    check(n, 3);
    check(loud, 1'b1);
    rdReg(ADDR_LEFT);
    check(rd[7], 1'b0);
    toneCapableMode = 1'b0;
    waitTick();
    wr(ADDR_LEFT, 8'h80);
    waitTick();
    waitTick();
    check(toneActive, 1'b0);
    rdReg(ADDR_LEFT);
    check(rd[7], 1'b1);
    toneCapableMode = 1'b1;
    play(n);
    check(n, 3);
    $display("test tone done");
    wr(ADDR_LEN_MID, 8'h01);
    waitTick();
    wr(ADDR_LEFT, 8'h80);
    waitTick();
    check(toneActive, 1'b1);
    wr(ADDR_LEFT, 8'h00);
    repeat (2) @(negedge mclk);
    check(toneActive, 1'b0);
    wr(ADDR_LEN_MID, 8'h00);
    wr(ADDR_LEN_LO, 8'h00);
    waitTick();
    wr(ADDR_LEFT, 8'h80);
    play(n);
    check(n, 0);
    $display("test stop done");
    complete_run();
  end
endmodule : test_compressor_rates_and_tone_control
`default_nettype wire
